// ===== include/spimfc_pkg.sv
// shared constants for the spi master fifo controller
package spimfc_pkg;
    // data path and fifo geometry
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int LEVEL_W = 5;
    // frame length field holds length minus one
    localparam logic [3:0] MIN_LEN_M1 = 4'h3;
    localparam logic [3:0] MAX_LEN_M1 = 4'hf;
    // number of slave select lines
    localparam int NUM_SS = 3;
    localparam logic [2:0] SS_IDLE = 3'h7;
    // divider and sample delay widths
    localparam int DIV_W = 16;
    localparam int DLY_W = 8;
    localparam logic [14:0] MIN_HALF = 15'h0001;
    // interrupt source positions in the mask and flag vectors
    localparam int IRQ_TX_EMPTY = 0;
    localparam int IRQ_TX_OVF = 1;
    localparam int IRQ_RX_FULL = 2;
    localparam int IRQ_RX_OVR = 3;
    localparam int IRQ_W = 4;
    // shift engine states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_SHIFT = 4'b0010,
        ST_DRAIN = 4'b0100,
        ST_DONE  = 4'b1000
    } spimfc_state_t;
endpackage

// ===== rtl/spimfc_fifo.sv
// synchronous flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module spimfc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // fill level
    output logic [AW:0] count
);
    logic [WIDTH-1:0] mem [DEPTH];  // storage, indexed by pointers
    logic [AW-1:0] wr_ptr;          // next slot to write
    logic [AW-1:0] rd_ptr;          // next slot to read
    logic do_wr;
    logic do_rd;

    // honest full and empty straight from the level
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    // storage write; no reset needed on data
    always_ff @(posedge clk)
    begin
        if (do_wr)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and level; flush empties in one cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n || flush)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (do_wr)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            // simultaneous push and pop leaves the level alone
            if (do_wr && !do_rd)
            begin
                count <= count + 1'b1;
            end
            else if (do_rd && !do_wr)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // spimfc_fifo
`default_nettype wire

// ===== rtl/spimfc_controller.sv
// spi master controller with transmit and receive fifos
`timescale 1ns/1ps
`default_nettype none
module spimfc_controller (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // configuration
    input wire logic CONTROLLER_ENABLE_FLAG,
    input wire logic [15:0] SERIAL_CLOCK_DIVISOR,
    input wire logic CLOCK_PHASE_SELECT,
    input wire logic CLOCK_POLARITY_SELECT,
    input wire logic [3:0] FRAME_LEN_M1,
    input wire logic [2:0] SLAVE_ENABLE,
    input wire logic [7:0] RX_SAMPLE_DELAY,
    input wire logic [3:0] TX_THRESHOLD_LEVEL,
    input wire logic [3:0] RX_THRESHOLD_LEVEL,
    input wire logic [3:0] IRQ_MASK,
    // data port, write side
    input wire logic DATA_WR,
    input wire logic [15:0] DATA_WDATA,
    output logic DATA_WREADY,
    // data port, read side
    input wire logic DATA_RD,
    output logic [15:0] DATA_RDATA,
    output logic DATA_RVALID,
    // status
    output logic BUSY,
    output logic [4:0] TX_LEVEL,
    output logic [4:0] RX_LEVEL,
    output logic TX_EMPTY_IRQ_FLAG,
    output logic TX_OVERFLOW_IRQ,
    output logic RX_FULL_IRQ,
    output logic RX_OVERRUN_IRQ,
    input wire logic TX_OVERFLOW_CLR,
    input wire logic RX_OVERRUN_CLR,
    output logic IRQ,
    // serial link
    output logic SCLK,
    output logic MOSI,
    input wire logic MISO,
    output logic [2:0] SS_N
);
    spimfc_pkg::spimfc_state_t state;  // shift engine state
    logic flush;                      // empties both fifos
    logic [14:0] half;                // half period in system clocks
    logic [14:0] half_cnt;            // half period counter
    logic tick;                       // one serial clock edge due
    logic [4:0] edge_cnt;             // edges done in this frame
    logic [4:0] last_edge;            // index of final edge
    logic [3:0] len_m1;               // clamped frame length minus one
    logic [15:0] tx_sh;               // outgoing shifter, left-aligned
    logic [15:0] rx_sh;               // incoming shifter, right-justified
    logic leading;                    // current edge is a leading edge
    logic sample_edge;                // capture miso on this edge
    logic shift_edge;                 // present next bit on this edge
    logic pend;                       // delayed capture outstanding
    logic [7:0] dly_cnt;              // delay counter to sample point
    logic start;                      // a new frame may begin
    logic [15:0] tx_head;             // transmit fifo head entry
    logic [15:0] tx_aligned;          // head entry with its first bit at the top
    logic tx_valid;
    logic tx_pop;
    logic rx_push;
    logic rx_ready;
    logic [3:0] flags;

    // left-align a right-justified entry so bit 15 leaves first
    function automatic logic [15:0] align(input logic [15:0] d, input logic [3:0] lm1);
        align = d << (4'hf - lm1);
    endfunction

    // clamp the frame length to the legal span
    assign len_m1 = (FRAME_LEN_M1 < spimfc_pkg::MIN_LEN_M1) ? spimfc_pkg::MIN_LEN_M1 : FRAME_LEN_M1;
    assign last_edge = {len_m1, 1'b1};
    // the lsb of the divisor is dropped so the ratio stays even
    assign half = (SERIAL_CLOCK_DIVISOR[15:1] == 15'h0000) ? spimfc_pkg::MIN_HALF
                                                            : SERIAL_CLOCK_DIVISOR[15:1];
    assign tick = (half_cnt == half - 15'h0001);
    assign leading = !edge_cnt[0];
    assign sample_edge = CLOCK_PHASE_SELECT ? !leading : leading;
    assign shift_edge = CLOCK_PHASE_SELECT ? leading : (!leading && edge_cnt != last_edge);
    assign flush = !CONTROLLER_ENABLE_FLAG;
    assign start = CONTROLLER_ENABLE_FLAG && tx_valid && (SLAVE_ENABLE != 3'h0);
    assign tx_pop = start && (state == spimfc_pkg::ST_IDLE || state == spimfc_pkg::ST_DONE);
    assign rx_push = (state == spimfc_pkg::ST_DONE);
    // a function result cannot be bit-selected, so the aligned word gets a net of its own
    assign tx_aligned = align(tx_head, len_m1);

    // transmit fifo: software fills, the shift engine drains
    spimfc_fifo #(.WIDTH(spimfc_pkg::DATA_W), .DEPTH(spimfc_pkg::FIFO_DEPTH), .AW(4)) u_tx_fifo (
        .clk(CLOCK), .rst_n(RST_N), .flush(flush), .in_valid(DATA_WR), .in_ready(DATA_WREADY),
        .in_data(DATA_WDATA), .out_valid(tx_valid), .out_ready(tx_pop), .out_data(tx_head), .count(TX_LEVEL));

    // receive fifo: engine fills one frame per entry, software drains
    spimfc_fifo #(.WIDTH(spimfc_pkg::DATA_W), .DEPTH(spimfc_pkg::FIFO_DEPTH), .AW(4)) u_rx_fifo (
        .clk(CLOCK), .rst_n(RST_N), .flush(flush), .in_valid(rx_push), .in_ready(rx_ready),
        .in_data(rx_sh), .out_valid(DATA_RVALID), .out_ready(DATA_RD), .out_data(DATA_RDATA), .count(RX_LEVEL));

    // engine state machine
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            state <= spimfc_pkg::ST_IDLE;
        end
        else if (flush)
        begin
            state <= spimfc_pkg::ST_IDLE;
        end
        else
        begin
            case (state)
                spimfc_pkg::ST_IDLE:
                    state <= start ? spimfc_pkg::ST_SHIFT : spimfc_pkg::ST_IDLE;
                spimfc_pkg::ST_SHIFT:
                    state <= (tick && edge_cnt == last_edge) ? spimfc_pkg::ST_DRAIN : spimfc_pkg::ST_SHIFT;
                // wait for a late sample and give the slave a hold half period
                spimfc_pkg::ST_DRAIN:
                    state <= (tick && !pend) ? spimfc_pkg::ST_DONE : spimfc_pkg::ST_DRAIN;
                // another queued frame follows with select still low
                spimfc_pkg::ST_DONE:
                    state <= start ? spimfc_pkg::ST_SHIFT : spimfc_pkg::ST_IDLE;
                default:
                    state <= spimfc_pkg::ST_IDLE;
            endcase
        end
    end

    // half period timer, restarted at every frame boundary
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N || state == spimfc_pkg::ST_IDLE || state == spimfc_pkg::ST_DONE)
        begin
            half_cnt <= '0;
        end
        else
        begin
            half_cnt <= tick ? 15'h0000 : half_cnt + 15'h0001;
        end
    end

    // edge counter within a frame
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N || state != spimfc_pkg::ST_SHIFT)
        begin
            edge_cnt <= '0;
        end
        else if (tick)
        begin
            edge_cnt <= edge_cnt + 5'h01;
        end
    end

    // serial clock: rests at polarity level, toggles on each edge
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            SCLK <= 1'b0;
        end
        else if (state != spimfc_pkg::ST_SHIFT)
        begin
            SCLK <= CLOCK_POLARITY_SELECT;
        end
        else if (tick)
        begin
            SCLK <= ~SCLK;
        end
    end

    // slave selects: taken at frame start, released when the queue runs dry
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N || flush)
        begin
            SS_N <= spimfc_pkg::SS_IDLE;
        end
        else if (tx_pop)
        begin
            SS_N <= ~SLAVE_ENABLE;
        end
        else if (state == spimfc_pkg::ST_DONE)
        begin
            SS_N <= spimfc_pkg::SS_IDLE;
        end
    end

    // outgoing shifter and data line
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            tx_sh <= '0;
            MOSI <= 1'b0;
        end
        else if (tx_pop)
        begin
            // phase zero drives the first bit ahead of the first edge
            if (!CLOCK_PHASE_SELECT)
            begin
                MOSI <= tx_aligned[15];
                tx_sh <= tx_aligned << 1;
            end
            else
            begin
                tx_sh <= tx_aligned;
            end
        end
        else if (state == spimfc_pkg::ST_SHIFT && tick && shift_edge)
        begin
            MOSI <= tx_sh[15];
            tx_sh <= tx_sh << 1;
        end
    end

    // sample point delay; must stay below one half period
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N || state == spimfc_pkg::ST_IDLE)
        begin
            pend <= 1'b0;
            dly_cnt <= '0;
        end
        else if (state == spimfc_pkg::ST_SHIFT && tick && sample_edge && RX_SAMPLE_DELAY != 8'h00)
        begin
            pend <= 1'b1;
            dly_cnt <= RX_SAMPLE_DELAY;
        end
        else if (pend)
        begin
            dly_cnt <= dly_cnt - 8'h01;
            pend <= (dly_cnt != 8'h01);
        end
    end

    // incoming shifter; fresh frame starts from zero so it lands right-justified
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N || tx_pop)
        begin
            rx_sh <= '0;
        end
        else if ((state == spimfc_pkg::ST_SHIFT && tick && sample_edge && RX_SAMPLE_DELAY == 8'h00)
                 || (pend && dly_cnt == 8'h01))
        begin
            rx_sh <= {rx_sh[14:0], MISO};
        end
    end

    // sticky overflow and overrun; a new event beats a same-cycle clear
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            TX_OVERFLOW_IRQ <= 1'b0;
            RX_OVERRUN_IRQ <= 1'b0;
        end
        else
        begin
            TX_OVERFLOW_IRQ <= (DATA_WR && !DATA_WREADY) || (TX_OVERFLOW_IRQ && !TX_OVERFLOW_CLR);
            RX_OVERRUN_IRQ <= (rx_push && !rx_ready) || (RX_OVERRUN_IRQ && !RX_OVERRUN_CLR);
        end
    end

    // level flags follow the fifo counts
    assign TX_EMPTY_IRQ_FLAG = (TX_LEVEL <= {1'b0, TX_THRESHOLD_LEVEL});
    assign RX_FULL_IRQ = (RX_LEVEL >= {1'b0, RX_THRESHOLD_LEVEL} + 5'h01);
    assign BUSY = (state != spimfc_pkg::ST_IDLE);
    assign flags = {RX_OVERRUN_IRQ, RX_FULL_IRQ, TX_OVERFLOW_IRQ, TX_EMPTY_IRQ_FLAG};
    assign IRQ = |(flags & IRQ_MASK);

    // checks
    AST_SS_IDLE: assert property (@(posedge CLOCK) disable iff (!RST_N)
        state == spimfc_pkg::ST_IDLE && $past(state == spimfc_pkg::ST_IDLE) |-> SS_N == spimfc_pkg::SS_IDLE)
        else $error("slave select low while idle");
    AST_SCLK_REST: assert property (@(posedge CLOCK) disable iff (!RST_N)
        state == spimfc_pkg::ST_IDLE && $past(state == spimfc_pkg::ST_IDLE) && $stable(CLOCK_POLARITY_SELECT)
        |-> SCLK == CLOCK_POLARITY_SELECT)
        else $error("serial clock not at rest level");
    AST_FIRST_BIT: assert property (@(posedge CLOCK) disable iff (!RST_N)
        tx_pop && !CLOCK_PHASE_SELECT |=> MOSI == $past(tx_aligned[15]))
        else $error("first bit not driven before first edge");
    AST_TX_EMPTY: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (TX_LEVEL <= {1'b0, TX_THRESHOLD_LEVEL}) == TX_EMPTY_IRQ_FLAG)
        else $error("tx empty flag wrong");
    AST_RX_FULL: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (RX_LEVEL > {1'b0, RX_THRESHOLD_LEVEL}) == RX_FULL_IRQ)
        else $error("rx full flag wrong");
    AST_OVF: assert property (@(posedge CLOCK) disable iff (!RST_N)
        DATA_WR && TX_LEVEL == 5'h10 |=> TX_OVERFLOW_IRQ)
        else $error("overflow not flagged");
    AST_OVR: assert property (@(posedge CLOCK) disable iff (!RST_N)
        rx_push && RX_LEVEL == 5'h10 && !DATA_RD && CONTROLLER_ENABLE_FLAG |=> RX_OVERRUN_IRQ && RX_LEVEL == 5'h10)
        else $error("overrun not flagged");
    AST_FLUSH: assert property (@(posedge CLOCK) disable iff (!RST_N)
        !CONTROLLER_ENABLE_FLAG |=> TX_LEVEL == 5'h00 && RX_LEVEL == 5'h00 && !BUSY)
        else $error("fifos not emptied on disable");
    AST_BUSY_SEL: assert property (@(posedge CLOCK) disable iff (!RST_N)
        BUSY && CONTROLLER_ENABLE_FLAG |-> SS_N != spimfc_pkg::SS_IDLE)
        else $error("busy without a selected slave");
    COV_FRAME: cover property (@(posedge CLOCK) disable iff (!RST_N) rx_push && rx_ready);
    COV_BACK2BACK: cover property (@(posedge CLOCK) disable iff (!RST_N)
        state == spimfc_pkg::ST_DONE && start);
    COV_OVERRUN: cover property (@(posedge CLOCK) disable iff (!RST_N) rx_push && !rx_ready);
endmodule // spimfc_controller
`default_nettype wire

// ===== verification/spimfc_slave_model.sv
// behavioural spi slave that answers the controller on the far side of the link
`timescale 1ns/1ps
`default_nettype none
module spimfc_slave_model #(
    parameter logic [15:0] SEED = 16'h5a3c
) (
    // system clock, only used for the released line pattern
    input wire logic clk,
    // serial link
    input wire logic sclk,
    input wire logic mosi,
    input wire logic ss_n,
    output logic miso,
    // mode, set the same as the controller
    input wire logic cpol,
    input wire logic cpha,
    input wire logic [4:0] len
);
    logic [15:0] got [0:127]; // frames captured from mosi
    int frames = 0; // completed frames
    int falls = 0; // select assertions seen
    int per = 0; // last in-frame clock period in ns
    int cnt = 0; // bits sampled in this frame
    logic [15:0] sh = 16'h0; // reply word being sent
    logic [15:0] rx = 16'h0; // incoming shift register
    logic drv = 1'b0; // bit driven while selected
    logic junk = 1'b0; // toggling pattern when released
    time tlast = 0;
    // a released line toggles each clock so a stale bit can never pass as data
    always @(posedge clk) junk <= ~junk;
    assign miso = ss_n ? junk : drv;
    // select fall opens a frame
    always @(negedge ss_n)
    begin
        falls = falls + 1;
        cnt = 0;
        sh = SEED + 16'(frames) * 16'h3b1d;
        if (!cpha)
            drv = sh[len - 5'h1];
    end
    // sample on one edge kind, drive on the other
    always @(sclk)
    begin
        if (ss_n === 1'b0)
        begin
            if ((sclk != cpol) ^ cpha)
            begin
                if (cnt > 0)
                    per = int'($time - tlast);
                tlast = $time;
                rx = {rx[14:0], mosi};
                cnt = cnt + 1;
                // frame complete, next reply ready for a held select
                if (cnt == int'(len))
                begin
                    got[frames % 128] = rx & (16'hffff >> (16 - int'(len)));
                    frames = frames + 1;
                    cnt = 0;
                    sh = SEED + 16'(frames) * 16'h3b1d;
                end
            end
            else
                drv = sh[int'(len) - 1 - cnt];
        end
    end
endmodule // spimfc_slave_model
`default_nettype wire

// ===== verification/test_spimfc_controller.sv
// self-checking bench for the spi master fifo controller
`timescale 1ns/1ps
`default_nettype none
module test_spimfc_controller;
    // clock, reset and configuration
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic en = 1'b1;
    logic [15:0] div = 16'h0002;
    logic cpha = 1'b0;
    logic cpol = 1'b0;
    logic [3:0] len_m1 = 4'h7;
    logic [2:0] slv = 3'h1;
    logic [7:0] dly = 8'h00;
    logic [3:0] txt = 4'h0;
    logic [3:0] rxt = 4'h0;
    logic [3:0] mask = 4'h0;
    // data port and clear strobes
    logic wr = 1'b0;
    logic [15:0] wd = 16'h0;
    logic rd = 1'b0;
    logic txc = 1'b0;
    logic rxc = 1'b0;
    // design outputs
    logic wready, rvalid, busy, txe, txo, rxf, rxo, irq, sclk, mosi, miso;
    logic [15:0] rdata;
    logic [4:0] txl, rxl;
    logic [2:0] ss_n;
    int mismatches = 0;
    int checked = 0;
    logic [31:0] rs = 32'd64081; // xorshift state, fixed seed
    always #2.5 clock = ~clock;
    spimfc_controller uut (.CLOCK(clock), .RST_N(rst_n), .CONTROLLER_ENABLE_FLAG(en),
        .SERIAL_CLOCK_DIVISOR(div), .CLOCK_PHASE_SELECT(cpha), .CLOCK_POLARITY_SELECT(cpol),
        .FRAME_LEN_M1(len_m1), .SLAVE_ENABLE(slv), .RX_SAMPLE_DELAY(dly), .TX_THRESHOLD_LEVEL(txt),
        .RX_THRESHOLD_LEVEL(rxt), .IRQ_MASK(mask), .DATA_WR(wr), .DATA_WDATA(wd), .DATA_WREADY(wready),
        .DATA_RD(rd), .DATA_RDATA(rdata), .DATA_RVALID(rvalid), .BUSY(busy), .TX_LEVEL(txl), .RX_LEVEL(rxl),
        .TX_EMPTY_IRQ_FLAG(txe), .TX_OVERFLOW_IRQ(txo), .RX_FULL_IRQ(rxf), .RX_OVERRUN_IRQ(rxo),
        .TX_OVERFLOW_CLR(txc), .RX_OVERRUN_CLR(rxc), .IRQ(irq), .SCLK(sclk), .MOSI(mosi), .MISO(miso),
        .SS_N(ss_n));
    spimfc_slave_model model (.clk(clock), .sclk(sclk), .mosi(mosi), .ss_n(&ss_n), .miso(miso),
        .cpol(cpol), .cpha(cpha), .len({1'b0, len_m1} + 5'h1));
    // xorshift step
    task automatic nx();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
    endtask
    // frame mask and the slave's reply for frame k
    function automatic logic [15:0] msk(input logic [3:0] m1);
        return 16'hffff >> (4'hf - m1);
    endfunction
    function automatic logic [15:0] reply(input int k);
        return 16'h5a3c + 16'(k) * 16'h3b1d;
    endfunction
    task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic chk_flag(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        if (mismatches == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // back-to-back writes, wait for the link to go quiet, check wire and fifo
    task automatic burst(input int n, input bit drain);
        logic [15:0] w [0:15];
        logic [2:0] low;
        int base;
        int f0;
        int g;
        base = model.frames;
        f0 = model.falls;
        low = 3'h7;
        for (int i = 0; i < n; i++)
        begin
            nx();
            w[i] = rs[15:0]; // upper bits left random on purpose
            wr = 1'b1;
            wd = w[i];
            @(negedge clock);
        end
        wr = 1'b0;
        g = 0;
        while ((busy !== 1'b0 || txl !== 5'h0) && g < 20000)
        begin
            if (busy === 1'b1)
                low = ss_n;
            g++;
            @(negedge clock);
        end
        repeat (2) @(negedge clock);
        chk_flag("busy after burst", 1'b0, busy);
        chk_word("selected line", {13'h0, ~slv}, {13'h0, low});
        chk_word("select falls", 16'h1, 16'(model.falls - f0));
        chk_word("clock period", 16'(div[3:1] * 10), 16'(model.per));
        chk_flag("idle clock", cpol, sclk);
        chk_word("idle selects", 16'h7, {13'h0, ss_n});
        for (int i = 0; i < n; i++)
        begin
            chk_word("mosi frame", w[i] & msk(len_m1), model.got[(base + i) % 128]);
            if (drain)
            begin
                chk_word("rx entry", reply(base + i) & msk(len_m1), rdata);
                rd = 1'b1;
                @(negedge clock);
            end
        end
        rd = 1'b0;
    endtask
    // watchdog, well beyond the longest possible run of under 12000 cycles
    initial
    begin
        repeat (50000) @(posedge clock);
        mismatches++;
        end_of_test();
    end
    // main sequence
    initial
    begin
        int b0;
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        @(negedge clock);
        chk_word("reset selects", 16'h7, {13'h0, ss_n});
        chk_flag("reset busy", 1'b0, busy);
        chk_flag("reset write ready", 1'b1, wready);
        // no slave selected: fill the tx fifo and watch the threshold flag
        slv = 3'h0;
        mask = 4'h2;
        nx();
        txt = rs[3:0];
        for (int k = 1; k <= 16; k++)
        begin
            wr = 1'b1;
            wd = rs[15:0];
            @(negedge clock);
            chk_flag("tx empty flag", k <= int'(txt), txe);
            chk_flag("busy without slave", 1'b0, busy);
        end
        chk_flag("write ready when full", 1'b0, wready);
        @(negedge clock);
        wr = 1'b0;
        chk_word("tx level", 16'h10, {11'h0, txl});
        chk_flag("tx overflow", 1'b1, txo);
        chk_flag("irq", 1'b1, irq);
        mask = 4'h0;
        txc = 1'b1;
        @(negedge clock);
        txc = 1'b0;
        chk_flag("masked irq", 1'b0, irq);
        chk_flag("tx overflow cleared", 1'b0, txo);
        en = 1'b0;
        @(negedge clock);
        en = 1'b1;
        @(negedge clock);
        chk_word("flushed tx level", 16'h0, {11'h0, txl});
        // all four clock modes with random shapes, then short and long frames
        for (int m = 0; m < 8; m++)
        begin
            nx();
            cpol = m[0];
            cpha = m[1];
            len_m1 = (m == 4) ? 4'h3 : (m == 5) ? 4'hf : 4'(3 + rs[3:0] % 13);
            div = (m == 6) ? 16'h0009 : 16'(2 + rs[7:4] % 8); // odd divisors round down to even
            slv = 3'(1 << (rs[9:8] % 3));
            // one pass always takes the longest sample delay that fits in a half period
            dly = (m == 6) ? 8'h03 : 8'(rs[13:10] % div[3:1]);
            repeat (4) @(negedge clock);
            burst(1 + int'(rs[16:14]), 1'b1);
            chk_flag("rx drained", 1'b0, rvalid);
        end
        // fill the rx fifo past full
        mask = 4'h8;
        b0 = model.frames;
        burst(9, 1'b0);
        rxt = 4'h8;
        @(negedge clock);
        chk_flag("rx full at threshold", 1'b1, rxf);
        rxt = 4'h9;
        @(negedge clock);
        chk_flag("rx full below threshold", 1'b0, rxf);
        chk_flag("irq before overrun", 1'b0, irq);
        burst(8, 1'b0);
        chk_word("rx level", 16'h10, {11'h0, rxl});
        chk_flag("rx overrun", 1'b1, rxo);
        chk_flag("irq on overrun", 1'b1, irq);
        // the seventeenth frame must be gone
        for (int i = 0; i < 16; i++)
        begin
            chk_word("kept entry", reply(b0 + i) & msk(len_m1), rdata);
            rd = 1'b1;
            @(negedge clock);
        end
        rd = 1'b0;
        rxc = 1'b1;
        @(negedge clock);
        rxc = 1'b0;
        @(negedge clock);
        chk_flag("rx empty", 1'b0, rvalid);
        chk_flag("rx overrun cleared", 1'b0, rxo);
        end_of_test();
    end
endmodule // test_spimfc_controller
`default_nettype wire
